/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfl_cfg.svh"

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_top
    import pfl_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [1:0] regByteEn = 2'b00;
    logic [15:0] regWrData = 16'h0000;
    logic regRdValid;
    logic [15:0] regRdData;
    logic rxValid = 1'b0;
    pfl_rx_msg_type rxMsg = '0;
    logic rxOutValid;
    logic rxForward;
    logic [63:0] rxCorrection;
    logic txValid = 1'b0;
    pfl_tx_msg_type txMsg = '0;
    logic txOutValid;
    logic [15:0] txChecksum;
    logic [63:0] txCorrection;
    logic announceFromPort1;
    logic [15:0] rxDelay;
    logic [15:0] txDelay;
    logic [15:0] linkDelay;
    int mismatches = 0;
    int compares = 0;
    logic [31:0] seed = 32'h0000_5ed8;
    logic [31:0] x;
    logic [15:0] regs[logic [11:0]];
    logic [15:0] regQ[$];
    logic [64:0] rxQ[$];
    logic [79:0] txQ[$];
    logic [15:0] regExp;
    logic [64:0] rxExp;
    logic [79:0] txExp;
    logic [11:0] addrs[7] = '{12'h622, 12'h624, 12'h640, 12'h642, 12'h644, 12'h646, 12'h626};
    pfl_msg_kind_type kinds[5] = '{PFL_MSG_SYNC, PFL_MSG_DELAY_REQ, PFL_MSG_PDELAY_REQ,
                                   PFL_MSG_PDELAY_RESP, PFL_MSG_OTHER};

    pfl_ptp_filter DUT (
        .core_clk(core_clk), .reset(reset),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regByteEn(regByteEn),
        .regWrData(regWrData), .regRdValid(regRdValid), .regRdData(regRdData),
        .rxValid(rxValid), .rxMsg(rxMsg), .rxOutValid(rxOutValid), .rxForward(rxForward),
        .rxCorrection(rxCorrection),
        .txValid(txValid), .txMsg(txMsg), .txOutValid(txOutValid), .txChecksum(txChecksum),
        .txCorrection(txCorrection),
        .announceFromPort1(announceFromPort1), .rxDelay(rxDelay), .txDelay(txDelay),
        .linkDelay(linkDelay)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic busCycle(input logic w, input logic r, input logic [11:0] a, input logic [1:0] be,
                            input logic [15:0] d);
        @(negedge core_clk);
        regWrite = w;
        regRead = r;
        regAddr = a;
        regByteEn = be;
        regWrData = d;
    endtask

    task automatic idle();
        @(negedge core_clk);
        regWrite = 1'b0;
        regRead = 1'b0;
        rxValid = 1'b0;
        txValid = 1'b0;
    endtask

    // Unmapped writes are dropped and read-only bits stay at their default of zero.
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
        logic [15:0] v;
        if (regs.exists(a)) begin
            v = regs[a];
            if (be[0]) v[7:0] = d[7:0];
            if (be[1]) v[15:8] = d[15:8];
            regs[a] = v & (a == 12'h622 ? 16'h1FB7 : a == 12'h624 ? 16'h0FFF : 16'hFFFF);
        end
        busCycle(1'b1, 1'b0, a, be, d);
    endtask

    task automatic rd(input logic [11:0] a);
        regQ.push_back(regs.exists(a) ? regs[a] : 16'h0000);
        busCycle(1'b0, 1'b1, a, 2'b00, 16'h0000);
    endtask

    // One received and one egress message in the same cycle, expectations noted first.
    task automatic traffic(input int n);
        logic [31:0] y;
        logic [31:0] z;
        logic [63:0] mag;
        logic [63:0] rc;
        logic [63:0] tc;
        logic [15:0] ck;
        logic fwd;
        pfl_rx_msg_type r;
        pfl_tx_msg_type t;
        x = rnd();
        y = rnd();
        z = rnd();
        r.domain = x[0] ? regs[12'h624][7:0] : x[15:8];
        r.version = x[1] ? regs[12'h624][11:8] : x[19:16];
        r.kind = kinds[n % 5];
        r.defaultForward = x[2];
        r.correction = {y, z};
        t.isIpv6 = x[3];
        t.modified = x[4];
        t.origChecksum = x[5] ? 16'h0000 : y[15:0];
        t.newChecksum = z[31:16];
        t.kind = kinds[(n + 2) % 5];
        t.correction = {z, y};
        mag = {33'h0, regs[12'h644][14:0], 16'h0000};
        fwd = (r.version != regs[12'h624][11:8]) ? 1'b0 :
              regs[12'h622][4] ? (r.domain == regs[12'h624][7:0]) : r.defaultForward;
        rc = r.correction;
        if (r.kind == PFL_MSG_SYNC || r.kind == PFL_MSG_PDELAY_RESP)
            rc = regs[12'h644][15] ? rc - mag : rc + mag;
        tc = t.correction;
        if (t.kind == PFL_MSG_DELAY_REQ || t.kind == PFL_MSG_PDELAY_REQ)
            tc = regs[12'h644][15] ? tc + mag : tc - mag;
        if (t.isIpv6)
            ck = t.modified ? t.newChecksum : t.origChecksum;
        else if (t.origChecksum == 16'h0000 || !regs[12'h622][2])
            ck = 16'h0000;
        else
            ck = t.modified ? t.newChecksum : t.origChecksum;
        rxQ.push_back({fwd, rc});
        txQ.push_back({ck, tc});
        @(negedge core_clk);
        regWrite = 1'b0;
        regRead = 1'b0;
        rxValid = 1'b1;
        rxMsg = r;
        txValid = 1'b1;
        txMsg = t;
    endtask

    task automatic loadDefaults();
        regs[12'h622] = 16'h0404;
        regs[12'h624] = 16'h0200;
        regs[12'h640] = 16'h019F;
        regs[12'h642] = 16'h002D;
        regs[12'h644] = 16'h0000;
        regs[12'h646] = 16'h0000;
    endtask

    always @(negedge core_clk) begin
        if (regRdValid === 1'b1) begin
            regExp = regQ.size() > 0 ? regQ.pop_front() : 16'hxxxx;
            `CHK(regRdData, regExp)
        end
        if (rxOutValid === 1'b1) begin
            rxExp = rxQ.size() > 0 ? rxQ.pop_front() : 'x;
            `CHK({rxForward, rxCorrection}, rxExp)
        end
        if (txOutValid === 1'b1) begin
            txExp = txQ.size() > 0 ? txQ.pop_front() : 'x;
            `CHK({txChecksum, txCorrection}, txExp)
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end

    initial begin
        loadDefaults();
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        `CHK(rxDelay, 16'h019F)
        `CHK(txDelay, 16'h002D)
        `CHK(linkDelay, 16'h0000)
        `CHK(announceFromPort1, 1'b0)
        foreach (addrs[i]) rd(addrs[i]);
        foreach (addrs[i]) wr(addrs[i], 16'hFFFF, 2'b11);
        foreach (addrs[i]) rd(addrs[i]);
        wr(12'h624, 16'h1234, 2'b01);
        wr(12'h640, 16'hABCD, 2'b10);
        rd(12'h624);
        rd(12'h640);
        for (int i = 2; i < 6; i++) begin
            x = rnd();
            wr(addrs[i], x[15:0], 2'b11);
            rd(addrs[i]);
        end
        idle();
        `CHK(announceFromPort1, 1'b1)
        `CHK(rxDelay, regs[12'h640])
        `CHK(txDelay, regs[12'h642])
        `CHK(linkDelay, regs[12'h646])
        for (int c = 0; c < 4; c++) begin
            x = rnd();
            wr(12'h624, x[15:0], 2'b11);
            wr(12'h644, x[31:16], 2'b11);
            wr(12'h622, {11'h000, c[0], 1'b0, c[1], x[5], 1'b0}, 2'b11);
            rd(12'h622);
            for (int m = 0; m < 20; m++) traffic(c * 20 + m);
            idle();
            `CHK(announceFromPort1, regs[12'h622][1])
        end
        repeat (4) idle();
        // A reset in mid-run must bring every setting back to its default.
        reset = 1'b1;
        repeat (2) idle();
        reset = 1'b0;
        loadDefaults();
        `CHK({announceFromPort1, rxDelay, txDelay, linkDelay}, {1'b0, 16'h019F, 16'h002D, 16'h0000})
        foreach (addrs[i]) rd(addrs[i]);
        repeat (4) idle();
        `CHK(regQ.size() + rxQ.size() + txQ.size(), 0)
        stop_test();
    end
endmodule
`default_nettype wire

/* File: verilog/pfl_cfg.svh */
`ifndef PFL_CFG_SVH
`define PFL_CFG_SVH

`define PFL_ADDR_WIDTH 12
`define PFL_OFS_FILTER_CFG 12'h0622
`define PFL_OFS_DOMAIN_VER 12'h0624
`define PFL_OFS_RX_DELAY 12'h0640
`define PFL_OFS_TX_DELAY 12'h0642
`define PFL_OFS_ASYM 12'h0644
`define PFL_OFS_LINK_DELAY 12'h0646

`define PFL_FILTER_CFG_RESET 16'h0404
`define PFL_FILTER_CFG_WMASK 16'h1FB7
`define PFL_DOMAIN_VER_RESET 16'h0200
`define PFL_DOMAIN_VER_WMASK 16'h0FFF
`define PFL_RX_DELAY_RESET 16'h019F
`define PFL_TX_DELAY_RESET 16'h002D
`define PFL_ASYM_RESET 16'h0000
`define PFL_LINK_DELAY_RESET 16'h0000

`define PFL_BIT_DOMAIN_EN 4
`define PFL_BIT_CKSUM_EN 2
`define PFL_BIT_ANNOUNCE_P1 1
`define PFL_DOMAIN_LSB 0
`define PFL_VERSION_LSB 8
`define PFL_ASYM_SIGN 15
`define PFL_CORR_FRAC_BITS 16

`endif

/* File: verilog/pfl_corr_adjust.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfl_cfg.svh"

module pfl_corr_adjust
    import pfl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Message in.
    input wire logic inValid,
    input wire logic [63:0] inCorrection,
    input wire logic apply,
    input wire logic subtract,
    // Asymmetry setting, sign and magnitude.
    input wire logic [15:0] asym,
    // Message out.
    output logic outValid,
    output logic [63:0] outCorrection
);

    logic [63:0] magnitude;
    logic negative;
    logic [63:0] delta;
    logic next_outValid;
    logic [63:0] next_outCorrection;

    // The magnitude is whole nanoseconds; the correction field carries 16 fraction bits.
    assign magnitude = {33'h0_0000_0000, asym[14:0], 16'h0000};
    assign negative = asym[`PFL_ASYM_SIGN] ^ subtract;

    always_comb begin
        delta = negative ? 64'(-magnitude) : magnitude;
        next_outValid = inValid;
        next_outCorrection = outCorrection;
        if (inValid) begin
            next_outCorrection = apply ? 64'(inCorrection + delta) : inCorrection;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            outValid <= 1'b0;
            outCorrection <= 64'h0000_0000_0000_0000;
        end else begin
            outValid <= next_outValid;
            outCorrection <= next_outCorrection;
        end
    end

    AST_ADJUST_APPLY: assert property (@(posedge core_clk) disable iff (reset)
        inValid && apply |=> outValid && outCorrection == (($past(asym[15]) != $past(subtract))
            ? 64'($past(inCorrection) - {33'h0_0000_0000, $past(asym[14:0]), 16'h0000})
            : 64'($past(inCorrection) + {33'h0_0000_0000, $past(asym[14:0]), 16'h0000})))
        else $error("Correction not adjusted by the asymmetry.");
    AST_ADJUST_BYPASS: assert property (@(posedge core_clk) disable iff (reset)
        inValid && !apply |=> outCorrection == $past(inCorrection))
        else $error("Correction changed on a message that is not adjusted.");

endmodule
`default_nettype wire

/* File: verilog/pfl_pkg.sv */
`default_nettype none
package pfl_pkg;

    typedef enum logic [3:0] {
        PFL_MSG_SYNC = 4'h0,
        PFL_MSG_DELAY_REQ = 4'h1,
        PFL_MSG_PDELAY_REQ = 4'h2,
        PFL_MSG_PDELAY_RESP = 4'h3,
        PFL_MSG_OTHER = 4'hF
    } pfl_msg_kind_type;

    typedef enum logic [1:0] {
        PFL_DEC_NONE = 2'h0,
        PFL_DEC_RW = 2'h1
    } pfl_decode_type;

    typedef struct packed {
        logic [7:0] domain;
        logic [3:0] version;
        pfl_msg_kind_type kind;
        logic defaultForward;
        logic [63:0] correction;
    } pfl_rx_msg_type;

    typedef struct packed {
        logic isIpv6;
        logic modified;
        logic [15:0] origChecksum;
        logic [15:0] newChecksum;
        pfl_msg_kind_type kind;
        logic [63:0] correction;
    } pfl_tx_msg_type;

endpackage
`default_nettype wire

/* File: verilog/pfl_ptp_filter.sv */
// Behaviour
// - Domain check on: forward only matching domains.
// - Domain check off: default forwarding rules apply.
// - Egress IPv4 checksum recomputed if enabled, else zeroed.
// - Zero IPv4 checksum stays zero always.
// - IPv6 UDP checksum always updated.
// - Announce-from-port-1 bit, read-write, resets zero.
// - Version field must match configured value, else drop.
// - Configured domain byte, resets zero.
// - Receive latency register, resets to 415 ns.
// - Transmit latency register, resets to 45 ns.
// - Asymmetry is sign-magnitude, resets zero.
// - Add asymmetry on ingress Sync and Pdelay responses; subtract on egress requests.
// - Link delay register, resets zero.
`timescale 1ns/1ps
`default_nettype none
`include "pfl_cfg.svh"

module pfl_ptp_filter
    import pfl_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Host register port.
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [11:0] regAddr,
    input wire logic [1:0] regByteEn,
    input wire logic [15:0] regWrData,
    output logic regRdValid,
    output logic [15:0] regRdData,
    // Received time messages.
    input wire logic rxValid,
    input wire pfl_rx_msg_type rxMsg,
    output logic rxOutValid,
    output logic rxForward,
    output logic [63:0] rxCorrection,
    // Egress time messages.
    input wire logic txValid,
    input wire pfl_tx_msg_type txMsg,
    output logic txOutValid,
    output logic [15:0] txChecksum,
    output logic [63:0] txCorrection,
    // Settings used by the timestamp and link logic.
    output logic announceFromPort1,
    output logic [15:0] rxDelay,
    output logic [15:0] txDelay,
    output logic [15:0] linkDelay
);

    logic [15:0] filterCfg;
    logic [15:0] domainVer;
    logic [15:0] asymSetting;
    logic [15:0] next_filterCfg;
    logic [15:0] next_domainVer;
    logic [15:0] next_rxDelay;
    logic [15:0] next_txDelay;
    logic [15:0] next_asymSetting;
    logic [15:0] next_linkDelay;
    logic next_regRdValid;
    logic [15:0] next_regRdData;
    logic next_rxForward;
    logic next_txOutValid;
    logic [15:0] next_txChecksum;
    logic domainEnable;
    logic checksumEnable;
    logic [7:0] cfgDomain;
    logic [3:0] cfgVersion;
    logic versionOk;
    logic domainOk;
    logic rxApply;
    logic txApply;

    // Byte-lane merge under a write mask; read-only bits keep their stored value.
    function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [15:0] wdata,
                                              input logic [1:0] lanes, input logic [15:0] wmask);
        logic [15:0] result;
        result = old;
        for (int lane = 0; lane < 2; lane++) begin
            for (int b = 0; b < 8; b++) begin
                if (lanes[lane] && wmask[lane * 8 + b]) begin
                    result[lane * 8 + b] = wdata[lane * 8 + b];
                end
            end
        end
        return result;
    endfunction

    // Address decode shared by the write and the read path.
    function automatic pfl_decode_type decodeHit(input logic [11:0] addr, input logic [11:0] offset);
        return (addr == offset) ? PFL_DEC_RW : PFL_DEC_NONE;
    endfunction

    assign domainEnable = filterCfg[`PFL_BIT_DOMAIN_EN];
    assign checksumEnable = filterCfg[`PFL_BIT_CKSUM_EN];
    assign announceFromPort1 = filterCfg[`PFL_BIT_ANNOUNCE_P1];
    assign cfgDomain = domainVer[`PFL_DOMAIN_LSB +: 8];
    assign cfgVersion = domainVer[`PFL_VERSION_LSB +: 4];

    // Register writes.
    always_comb begin
        next_filterCfg = filterCfg;
        next_domainVer = domainVer;
        next_rxDelay = rxDelay;
        next_txDelay = txDelay;
        next_asymSetting = asymSetting;
        next_linkDelay = linkDelay;
        if (regWrite) begin
            if (decodeHit(regAddr, `PFL_OFS_FILTER_CFG) == PFL_DEC_RW) begin
                next_filterCfg = mergeWrite(filterCfg, regWrData, regByteEn, `PFL_FILTER_CFG_WMASK);
            end
            if (decodeHit(regAddr, `PFL_OFS_DOMAIN_VER) == PFL_DEC_RW) begin
                next_domainVer = mergeWrite(domainVer, regWrData, regByteEn, `PFL_DOMAIN_VER_WMASK);
            end
            if (decodeHit(regAddr, `PFL_OFS_RX_DELAY) == PFL_DEC_RW) begin
                next_rxDelay = mergeWrite(rxDelay, regWrData, regByteEn, 16'hFFFF);
            end
            if (decodeHit(regAddr, `PFL_OFS_TX_DELAY) == PFL_DEC_RW) begin
                next_txDelay = mergeWrite(txDelay, regWrData, regByteEn, 16'hFFFF);
            end
            if (decodeHit(regAddr, `PFL_OFS_ASYM) == PFL_DEC_RW) begin
                next_asymSetting = mergeWrite(asymSetting, regWrData, regByteEn, 16'hFFFF);
            end
            if (decodeHit(regAddr, `PFL_OFS_LINK_DELAY) == PFL_DEC_RW) begin
                next_linkDelay = mergeWrite(linkDelay, regWrData, regByteEn, 16'hFFFF);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            filterCfg <= `PFL_FILTER_CFG_RESET;
            domainVer <= `PFL_DOMAIN_VER_RESET;
            rxDelay <= `PFL_RX_DELAY_RESET;
            txDelay <= `PFL_TX_DELAY_RESET;
            asymSetting <= `PFL_ASYM_RESET;
            linkDelay <= `PFL_LINK_DELAY_RESET;
        end else begin
            filterCfg <= next_filterCfg;
            domainVer <= next_domainVer;
            rxDelay <= next_rxDelay;
            txDelay <= next_txDelay;
            asymSetting <= next_asymSetting;
            linkDelay <= next_linkDelay;
        end
    end

    // Register reads; unmapped addresses read as zero.
    always_comb begin
        next_regRdValid = regRead;
        next_regRdData = regRdData;
        if (regRead) begin
            next_regRdData = 16'h0000;
            if (decodeHit(regAddr, `PFL_OFS_FILTER_CFG) == PFL_DEC_RW) begin
                next_regRdData = filterCfg;
            end
            if (decodeHit(regAddr, `PFL_OFS_DOMAIN_VER) == PFL_DEC_RW) begin
                next_regRdData = domainVer;
            end
            if (decodeHit(regAddr, `PFL_OFS_RX_DELAY) == PFL_DEC_RW) begin
                next_regRdData = rxDelay;
            end
            if (decodeHit(regAddr, `PFL_OFS_TX_DELAY) == PFL_DEC_RW) begin
                next_regRdData = txDelay;
            end
            if (decodeHit(regAddr, `PFL_OFS_ASYM) == PFL_DEC_RW) begin
                next_regRdData = asymSetting;
            end
            if (decodeHit(regAddr, `PFL_OFS_LINK_DELAY) == PFL_DEC_RW) begin
                next_regRdData = linkDelay;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            regRdValid <= 1'b0;
            regRdData <= 16'h0000;
        end else begin
            regRdValid <= next_regRdValid;
            regRdData <= next_regRdData;
        end
    end

    // Receive filtering: version first, then the domain when checking is on.
    assign versionOk = (rxMsg.version == cfgVersion);
    assign domainOk = (rxMsg.domain == cfgDomain);

    always_comb begin
        next_rxForward = rxForward;
        if (rxValid) begin
            if (!versionOk) begin
                next_rxForward = 1'b0;
            end else if (domainEnable) begin
                next_rxForward = domainOk;
            end else begin
                next_rxForward = rxMsg.defaultForward;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rxForward <= 1'b0;
        end else begin
            rxForward <= next_rxForward;
        end
    end

    // Egress checksum: IPv6 always refreshed, a zero IPv4 checksum is left alone.
    always_comb begin
        next_txOutValid = txValid;
        next_txChecksum = txChecksum;
        if (txValid) begin
            if (txMsg.isIpv6) begin
                next_txChecksum = txMsg.modified ? txMsg.newChecksum : txMsg.origChecksum;
            end else if (txMsg.origChecksum == 16'h0000) begin
                next_txChecksum = 16'h0000;
            end else if (!checksumEnable) begin
                next_txChecksum = 16'h0000;
            end else begin
                next_txChecksum = txMsg.modified ? txMsg.newChecksum : txMsg.origChecksum;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            txOutValid <= 1'b0;
            txChecksum <= 16'h0000;
        end else begin
            txOutValid <= next_txOutValid;
            txChecksum <= next_txChecksum;
        end
    end

    assign rxApply = (rxMsg.kind == PFL_MSG_SYNC) || (rxMsg.kind == PFL_MSG_PDELAY_RESP);
    assign txApply = (txMsg.kind == PFL_MSG_DELAY_REQ) || (txMsg.kind == PFL_MSG_PDELAY_REQ);

    pfl_corr_adjust rxAdjust (
        .core_clk(core_clk),
        .reset(reset),
        .inValid(rxValid),
        .inCorrection(rxMsg.correction),
        .apply(rxApply),
        .subtract(1'b0),
        .asym(asymSetting),
        .outValid(rxOutValid),
        .outCorrection(rxCorrection)
    );

    pfl_corr_adjust txAdjust (
        .core_clk(core_clk),
        .reset(reset),
        .inValid(txValid),
        .inCorrection(txMsg.correction),
        .apply(txApply),
        .subtract(1'b1),
        .asym(asymSetting),
        .outValid(),
        .outCorrection(txCorrection)
    );

    AST_DOMAIN_DROP: assert property (@(posedge core_clk) disable iff (reset)
        rxValid && versionOk && domainEnable && !domainOk |=> rxOutValid && !rxForward)
        else $error("Message with another domain was forwarded.");
    AST_DOMAIN_PASS: assert property (@(posedge core_clk) disable iff (reset)
        rxValid && versionOk && domainEnable && domainOk |=> rxOutValid && rxForward)
        else $error("Message with the configured domain was dropped.");
    AST_DEFAULT_RULE: assert property (@(posedge core_clk) disable iff (reset)
        rxValid && versionOk && !domainEnable |=> rxForward == $past(rxMsg.defaultForward))
        else $error("Default forwarding not followed with domain check off.");
    AST_VERSION_DROP: assert property (@(posedge core_clk) disable iff (reset)
        rxValid && (rxMsg.version != domainVer[11:8]) |=> !rxForward)
        else $error("Message with another version was forwarded.");
    AST_CKSUM_OFF: assert property (@(posedge core_clk) disable iff (reset)
        txValid && !txMsg.isIpv6 && !filterCfg[2] |=> txOutValid && txChecksum == 16'h0000)
        else $error("IPv4 checksum not zeroed with generation off.");
    AST_CKSUM_ON: assert property (@(posedge core_clk) disable iff (reset)
        txValid && !txMsg.isIpv6 && filterCfg[2] && txMsg.modified && txMsg.origChecksum != 16'h0000
        |=> txChecksum == $past(txMsg.newChecksum))
        else $error("IPv4 checksum not regenerated.");
    AST_CKSUM_ZERO_KEEP: assert property (@(posedge core_clk) disable iff (reset)
        txValid && !txMsg.isIpv6 && txMsg.origChecksum == 16'h0000 |=> txChecksum == 16'h0000)
        else $error("Zero IPv4 checksum was replaced.");
    AST_CKSUM_IPV6: assert property (@(posedge core_clk) disable iff (reset)
        txValid && txMsg.isIpv6 && txMsg.modified |=> txChecksum == $past(txMsg.newChecksum))
        else $error("IPv6 checksum not updated.");
    AST_ANNOUNCE_WRITE: assert property (@(posedge core_clk) disable iff (reset)
        regWrite && regAddr == 12'h622 && regByteEn[0] |=> announceFromPort1 == $past(regWrData[1]))
        else $error("Announce bit did not take the written value.");
    AST_RESET_VALUES: assert property (@(posedge core_clk)
        reset |=> rxDelay == 16'h019F && txDelay == 16'h002D && domainVer == 16'h0200 && linkDelay == 16'h0000)
        else $error("Register reset value wrong.");
    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (reset)
        regWrite |=> filterCfg[15:13] == 3'b000 && filterCfg[6] == 1'b0 && filterCfg[3] == 1'b0
        && domainVer[15:12] == 4'h0)
        else $error("Read-only reserved bit changed.");
    AST_READ_UNMAPPED: assert property (@(posedge core_clk) disable iff (reset)
        regRead && regAddr == 12'h626 |=> regRdValid && regRdData == 16'h0000)
        else $error("Unmapped address read not zero.");

    COV_DOMAIN_DROP: cover property (@(posedge core_clk) disable iff (reset)
        rxValid && domainEnable && !domainOk ##1 !rxForward);
    COV_IPV4_ZEROED: cover property (@(posedge core_clk) disable iff (reset)
        txValid && !txMsg.isIpv6 && !checksumEnable && txMsg.origChecksum != 16'h0000);
    COV_NEG_ASYM: cover property (@(posedge core_clk) disable iff (reset)
        rxValid && rxApply && asymSetting[15] && asymSetting[14:0] != 15'h0000);

endmodule
`default_nettype wire
